// [src/arb_pkg.sv]
`default_nettype none
package arb_pkg;

  // geometry and widths
  localparam int          ARB_DEPTH      = 1024;         // scans held in the ring
  localparam int          ARB_AW         = 10;           // pointer width
  localparam int          ARB_DW         = 32;           // one scan word
  localparam int          ARB_BLKS       = 16;           // most trigger blocks tracked
  localparam int          ARB_BW         = 5;            // block count width
  localparam int          ARB_STAT_OVR   = 7;            // weight-128 status bit position
  localparam logic [7:0]  ARB_STAT_RST   = 8'h00;        // status after reset
  localparam logic [ARB_AW-1:0] ARB_PTR_RST = '0;        // pointers after reset

  // block boundary record: first scan, trigger scan, pre-trigger present
  typedef struct packed {
    logic [ARB_AW-1:0] start;
    logic [ARB_AW-1:0] trig;
    logic              has_pre;
  } arb_blk_s;

  // scan written by the acquisition side
  typedef struct packed {
    logic              valid;
    logic [ARB_DW-1:0] data;
    logic              blk_start;    // first scan of a new trigger block
    logic              is_trig;      // trigger scan of the current block
  } arb_wr_s;

  // scan delivered to the host
  typedef struct packed {
    logic              valid;
    logic [ARB_DW-1:0] data;
    logic              corrupt;      // scan contents not to be trusted
  } arb_rd_s;

endpackage : arb_pkg
`default_nettype wire

// [src/arb_blk_table.sv]
`timescale 1ns/1ps
`default_nettype none
// ring of block boundary records; head entry is the oldest block
module arb_blk_table #(
  parameter int N  = 16,
  parameter int BW = 5
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // control
  input  wire logic                push,
  input  wire arb_pkg::arb_blk_s   push_rec,
  input  wire logic                pop,
  input  wire logic                clr,
  input  wire logic                clr_pre,   // head lost its pre-trigger area
  // view
  output arb_pkg::arb_blk_s        head,
  output arb_pkg::arb_blk_s        second,
  output logic [BW-1:0]            count
);
  import arb_pkg::*;

  // refuse sizes the count cannot hold
  if (N < 2 || (1 << BW) <= N)
  begin : g_bad_size
    $error("arb_blk_table: bad N/BW");
  end

  localparam int IW = $clog2(N);

  // record storage
  arb_blk_s        mem [N];
  logic [IW-1:0]   hd_r;
  logic [BW-1:0]   cnt_r;

  wire [IW-1:0] tail = IW'((hd_r + cnt_r[IW-1:0]) % N);
  wire [IW-1:0] nx   = IW'((hd_r + 1) % N);

  // pointer and count update
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hd_r  <= '0;
      cnt_r <= '0;
    end
    else if (clr)
    begin
      hd_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (pop && cnt_r != 0)
        hd_r <= nx;
      cnt_r <= BW'(cnt_r + BW'(push && cnt_r != N) - BW'(pop && cnt_r != 0));
    end
  end

  // record writes
  always_ff @(posedge sys_clk)
  begin
    if (push && !clr && cnt_r != N)
      mem[tail] <= push_rec;
    if (clr_pre && !clr)
      mem[hd_r].has_pre <= 1'b0;
  end

  assign head   = mem[hd_r];
  assign second = mem[nx];
  assign count  = cnt_r;

endmodule : arb_blk_table
`default_nettype wire

// [src/arb_ring.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R01: write and read pointers step per scan
// R02: write pointer wraps, overwriting oldest scans
// R03: single block overrun drops whole pre-trigger
// R04: reading pre-trigger then jumps to trigger
// R05: no pre-trigger left: drop oldest post-trigger
// R06: overwritten scan in transfer is erroneous
// R07: corrupt reads until flush or empty
// R08: multi-block overrun drops oldest whole block
// R09: read in dropped block jumps next block
// R10: survivors renumber, oldest becomes block one
// R11: acquisition never stalls, always overwrites
// R12: overrun sets weight-128 status bit
// R13: flush empties buffer, clears count, corrupt
module arb_ring #(
  parameter int DEPTH = arb_pkg::ARB_DEPTH,
  parameter int BLKS  = arb_pkg::ARB_BLKS
) (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // acquisition side
  input  wire arb_pkg::arb_wr_s         wr,
  // host side
  input  wire logic                     rd_req,
  input  wire logic                     flush,
  input  wire logic                     status_clr,
  output arb_pkg::arb_rd_s              rd,
  // state view
  output logic [7:0]                    status_byte_register,
  output logic [arb_pkg::ARB_BW-1:0]    blk_count,
  output logic [arb_pkg::ARB_AW:0]      scans_avail,
  output logic [arb_pkg::ARB_BW-1:0]    rd_blk_num
);
  import arb_pkg::*;

  // pointer widths come from the package, so sizes must match it
  if (DEPTH != (1 << ARB_AW) || BLKS != ARB_BLKS)
  begin : g_bad_size
    $error("arb_ring: bad size");
  end

  // scan memory
  logic [ARB_DW-1:0] mem [DEPTH];

  // whole module state
  typedef struct packed {
    logic [ARB_AW-1:0] wp;
    logic [ARB_AW-1:0] rp;
    logic [ARB_AW:0]   fill;
    logic              corrupt;
    logic [7:0]        stat;
    arb_rd_s           out;
    logic [ARB_AW-1:0] blk_st;     // first scan of block awaiting trigger
    logic              pend;       // block opened, trigger not yet seen
  } arb_st_s;

  arb_st_s st_r, st_nxt;

  // block table view and controls
  arb_blk_s         hd;
  arb_blk_s         sec;
  logic [ARB_BW-1:0] bcnt;
  logic             b_push;
  logic             b_pop;
  logic             b_clrpre;
  logic             b_clr;       // flush or read out until empty
  arb_blk_s         b_rec;

  // ring of block records, head is block one
  arb_blk_table #(
    .N  (BLKS),
    .BW (ARB_BW)
  ) u_tbl (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .push     (b_push),
    .push_rec (b_rec),
    .pop      (b_pop),
    .clr      (b_clr),
    .clr_pre  (b_clrpre),
    .head     (hd),
    .second   (sec),
    .count    (bcnt)
  );

  // helper terms
  logic              full;
  logic              ovr;
  logic              rd_go;
  logic [ARB_AW:0]   drop;
  logic [ARB_AW-1:0] newrp;
  logic              in_hd;

  // next state
  always_comb
  begin
    st_nxt   = st_r;
    b_push   = 1'b0;
    b_pop    = 1'b0;
    b_clrpre = 1'b0;
    b_clr    = 1'b0;
    b_rec    = '{start: st_r.blk_st, trig: st_r.wp, has_pre: 1'b1};
    full     = (st_r.fill == (ARB_AW+1)'(DEPTH));
    ovr      = wr.valid && full;
    rd_go    = rd_req && st_r.fill != 0;
    drop     = '0;
    newrp    = st_r.rp;
    in_hd    = 1'b1;
    st_nxt.out.valid = 1'b0;

    // host read delivers at read pointer
    if (rd_go)
    begin
      st_nxt.out.valid   = 1'b1;
      st_nxt.out.data    = mem[st_r.rp];
      st_nxt.out.corrupt = st_r.corrupt;                          // [R07]
      newrp = ARB_AW'(st_r.rp + 1'b1);                            // [R01]
      drop  = (ARB_AW+1)'(1);
      // read has left the oldest block: it is done with
      if (bcnt > 1 && newrp == sec.start)
        b_pop = 1'b1;                                             // [R10]
      // last scan read out: buffer counts as reset
      if (st_r.fill == (ARB_AW+1)'(1) && !wr.valid)
        b_clr = 1'b1;                                             // [R07]
    end

    // overrun handling; acquisition is never refused
    if (ovr)                                                      // [R11]
    begin
      st_nxt.stat[ARB_STAT_OVR] = 1'b1;                           // [R12]
      if (rd_go)
        st_nxt.corrupt = 1'b1;                                    // [R07]
      if (bcnt > 1)
      begin
        // drop oldest whole block, next becomes block one
        b_pop = 1'b1;                                             // [R08] [R10]
        // only the unread part of the head block leaves the count
        drop  = (ARB_AW+1)'(ARB_AW'(sec.start - st_r.rp));
        if (drop == 0)
          drop = (ARB_AW+1)'(DEPTH);
        newrp = sec.start;                                        // [R09]
        if (rd_go)
          st_nxt.out.corrupt = 1'b1;                              // [R09]
      end
      else if (bcnt == 1 && hd.has_pre && st_r.rp != hd.trig)
      begin
        // discard pre-trigger area at once
        b_clrpre = 1'b1;                                          // [R03]
        drop  = (ARB_AW+1)'(ARB_AW'(hd.trig - st_r.rp));
        newrp = hd.trig;                                          // [R04]
        if (rd_go)
          st_nxt.out.corrupt = 1'b1;                              // [R06]
      end
      else
      begin
        // drop the single oldest scan
        drop  = (ARB_AW+1)'(1);                                   // [R05]
        newrp = ARB_AW'(st_r.rp + 1'b1);
        if (rd_go)
          st_nxt.out.corrupt = 1'b1;                              // [R06]
      end
    end

    // a new block opens on its first scan; start kept until trigger
    if (wr.valid && wr.blk_start)
    begin
      st_nxt.blk_st = st_r.wp;
      st_nxt.pend   = !wr.is_trig;
    end

    // block is recorded once its trigger scan position is known
    if (wr.valid && wr.is_trig && (wr.blk_start || st_r.pend))
    begin
      b_push        = 1'b1;
      b_rec.start   = wr.blk_start ? st_r.wp : st_r.blk_st;
      b_rec.has_pre = !wr.blk_start;
      st_nxt.pend   = 1'b0;
    end

    // reading reached the trigger scan: pre-trigger area used up
    if (bcnt != 0 && hd.has_pre && st_r.rp == hd.trig)
      b_clrpre = 1'b1;                                            // [R05]

    st_nxt.rp   = newrp;
    st_nxt.fill = (ARB_AW+1)'(st_r.fill + (ARB_AW+1)'(wr.valid) - drop);
    if (wr.valid)
      st_nxt.wp = ARB_AW'(st_r.wp + 1'b1);                        // [R01] [R02]

    // drained to empty: buffer counts as reset
    if (st_nxt.fill == 0)
      st_nxt.corrupt = 1'b0;                                      // [R07]

    // status clear; a new overrun wins
    if (status_clr && !ovr)
      st_nxt.stat[ARB_STAT_OVR] = 1'b0;

    // flush empties everything
    if (flush)
    begin
      st_nxt.rp      = st_r.wp;                                   // [R13]
      st_nxt.wp      = st_r.wp;
      st_nxt.fill    = '0;
      st_nxt.pend    = 1'b0;
      b_clr          = 1'b1;                                      // [R13]
      st_nxt.corrupt = 1'b0;                                      // [R13]
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r.wp      <= ARB_PTR_RST;
      st_r.rp      <= ARB_PTR_RST;
      st_r.fill    <= '0;
      st_r.corrupt <= 1'b0;
      st_r.stat    <= ARB_STAT_RST;
      st_r.out     <= '0;
      st_r.blk_st  <= ARB_PTR_RST;
      st_r.pend    <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // scan storage, wraps over oldest data
  always_ff @(posedge sys_clk)
  begin
    if (wr.valid && !flush)
      mem[st_r.wp] <= wr.data;                                    // [R02]
  end

  // registered views
  logic [ARB_BW-1:0] bcnt_r;     // block count seen by the host
  logic [ARB_BW-1:0] blk_num_r;  // number of the block being read
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bcnt_r    <= '0;
      blk_num_r <= '0;
    end
    else
    begin
      bcnt_r    <= bcnt;
      // oldest block is always number one
      blk_num_r <= (bcnt != 0) ? ARB_BW'(1) : '0;                 // [R10]
    end
  end

  assign rd                   = st_r.out;
  assign status_byte_register = st_r.stat;
  assign scans_avail          = st_r.fill;
  assign blk_count            = bcnt_r;
  assign rd_blk_num           = blk_num_r;                        // [R10]

  // checks
  property p_wrap;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr.valid && !flush && st_r.wp == ARB_AW'(DEPTH-1)) |=> st_r.wp == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("write pointer did not wrap"); // [R02]

  property p_step;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr.valid && !flush) |=> st_r.wp == ARB_AW'($past(st_r.wp) + 1'b1);
  endproperty
  a_step: assert property (p_step) else $error("write pointer did not step"); // [R01]

  property p_ovr_stat;
    @(posedge sys_clk) disable iff (!rst_n)
      ovr |=> status_byte_register[ARB_STAT_OVR]
        ##1 (status_byte_register[ARB_STAT_OVR] || $past(status_clr));
  endproperty
  a_ovr_stat: assert property (p_ovr_stat) else $error("overrun bit not set"); // [R12]

  property p_flush;
    @(posedge sys_clk) disable iff (!rst_n)
      flush |=> (scans_avail == 0 && !st_r.corrupt && st_r.rp == st_r.wp);
  endproperty
  a_flush: assert property (p_flush) else $error("flush did not empty"); // [R13]

  property p_nodrop;
    @(posedge sys_clk) disable iff (!rst_n)
      (ovr && !flush) |=> st_r.wp != $past(st_r.wp);
  endproperty
  a_nodrop: assert property (p_nodrop) else $error("scan dropped in overrun"); // [R11]

  property p_pre;
    @(posedge sys_clk) disable iff (!rst_n)
      (ovr && !flush && bcnt == 1 && hd.has_pre && st_r.rp != hd.trig)
        |=> st_r.rp == $past(hd.trig);
  endproperty
  a_pre: assert property (p_pre) else $error("read not moved to trigger"); // [R03] [R04]

  property p_blk;
    @(posedge sys_clk) disable iff (!rst_n)
      (ovr && !flush && bcnt > 1 && !b_push)
        |=> (st_r.rp == $past(sec.start)) ##1 (bcnt_r == $past(bcnt, 2) - 1'b1);
  endproperty
  a_blk: assert property (p_blk) else $error("block not discarded"); // [R08] [R09] [R10]

  sequence s_corrupt_set;
    ovr && rd_go && !flush;
  endsequence
  property p_corrupt;
    @(posedge sys_clk) disable iff (!rst_n)
      s_corrupt_set ##1 (rd_go && !flush && !ovr && st_r.fill > 1) |=> rd.corrupt;
  endproperty
  a_corrupt: assert property (p_corrupt) else $error("later read not corrupt"); // [R07]

  property p_err;
    @(posedge sys_clk) disable iff (!rst_n)
      (ovr && rd_go && bcnt <= 1) |=> rd.corrupt;
  endproperty
  a_err: assert property (p_err) else $error("overwritten scan not flagged"); // [R06] [R05]

endmodule : arb_ring
`default_nettype wire

// [verif/arb_host.sv]
`timescale 1ns/1ps
`default_nettype none
// host side: reads scans, flushes, clears status
module arb_host (
  // clock
  input  wire logic             sys_clk,
  // commands to the ring
  output logic                  rd_req,
  output logic                  flush,
  output logic                  status_clr,
  // scan coming back
  input  wire arb_pkg::arb_rd_s rd
);
  import arb_pkg::*;

  // all commands idle from time zero
  initial
  begin
    rd_req = 1'b0;
    flush = 1'b0;
    status_clr = 1'b0;
  end

  // one read; answer sampled just after the edge that takes it;
  // hold keeps the request up so the next read follows back to back
  task automatic get(output logic [31:0] d, output logic c, output logic ok,
                     input logic hold = 1'b0);
    if (!rd_req)
    begin
      @(posedge sys_clk);
      rd_req <= 1'b1;
    end
    @(posedge sys_clk);
    rd_req <= hold;
    #1;
    ok = rd.valid;
    d = rd.data;
    c = rd.corrupt; // host takes this flag as untrusted data
  endtask : get

  // one-cycle flush and/or status clear pulse
  task automatic cmd(input logic f, input logic s);
    @(posedge sys_clk);
    flush <= f; // buffer reset ends corrupt reads
    status_clr <= s;
    @(posedge sys_clk);
    flush <= 1'b0;
    status_clr <= 1'b0;
  endtask : cmd
endmodule : arb_host
`default_nettype wire

// [verif/acquisition_ring_buffer_overrun_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// bench for the acquisition ring with overrun handling
module acquisition_ring_buffer_overrun_bench;
  import arb_pkg::*;

  logic                sys_clk = 1'b0;  // 200 MHz
  logic                rst_n   = 1'b0;  // async, active low
  arb_wr_s             wr      = '0;    // acquisition side
  logic                rd_req;          // host commands
  logic                flush;
  logic                status_clr;
  arb_rd_s             rd;              // scan out
  logic [7:0]          status_byte;     // status byte
  logic [ARB_BW-1:0]   blk_count;
  logic [ARB_AW:0]     avail;
  logic [ARB_BW-1:0]   blk_num;
  int                  n_errors  = 0;
  int                  tests_run = 0;
  logic [31:0]         d;               // last read
  logic                c;
  logic                ok;

  // clock
  always #2.5 sys_clk = ~sys_clk;

  // block under test
  arb_ring dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .wr(wr), .rd_req(rd_req), .flush(flush),
    .status_clr(status_clr), .rd(rd), .status_byte_register(status_byte),
    .blk_count(blk_count), .scans_avail(avail), .rd_blk_num(blk_num)
  );

  // host partner
  arb_host host (
    .sys_clk(sys_clk), .rd_req(rd_req), .flush(flush), .status_clr(status_clr), .rd(rd)
  );

  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // n scans back to back, marks only on the first
  task automatic wr_n(input int n, input int base, input logic bs, input logic tr);
    for (int i = 0; i < n; i++)
    begin
      @(posedge sys_clk);
      wr <= '{1'b1, 32'(base + i), bs && (i == 0), tr && (i == 0)};
    end
    @(posedge sys_clk);
    wr.valid <= 1'b0;
  endtask : wr_n

  // let registered views settle
  task automatic idle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : idle

  // read one scan and compare data and corrupt flag
  task automatic rd_chk(input logic [31:0] ed, input logic ec);
    host.get(d, c, ok);
    chk("valid", 32'(ok), 32'h1);
    chk("data", d, ed);
    chk("corrupt", 32'(c), 32'(ec));
  endtask : rd_chk

  // reset state, stepping pointers, refused empty read
  task automatic t_basic();
    idle();
    chk("status rst", 32'(status_byte), 32'(ARB_STAT_RST));
    chk("avail rst", 32'(avail), 32'h0);
    wr_n(3, 32'h10, 1'b1, 1'b1);
    idle();
    chk("avail", 32'(avail), 32'h3);
    chk("blk num", 32'(blk_num), 32'h1);
    for (int i = 0; i < 3; i++)
      rd_chk(32'h10 + i, 1'b0);
    host.get(d, c, ok);
    chk("empty read", 32'(ok), 32'h0);
  endtask : t_basic

  // single block with pre-trigger area, read partway
  task automatic t_pre();
    wr_n(10, 100, 1'b1, 1'b0);
    wr_n(1, 110, 1'b0, 1'b1);
    wr_n(1013, 111, 1'b0, 1'b0);
    rd_chk(100, 1'b0);
    rd_chk(101, 1'b0);
    wr_n(2, 2000, 1'b0, 1'b0);
    idle();
    chk("full", 32'(avail), 32'd1024);
    chk("no ovr", 32'(status_byte), 32'h0);
    wr_n(1, 2002, 1'b0, 1'b0);
    idle();
    chk("pre dropped", 32'(avail), 32'd1017);
    chk("ovr bit", 32'(status_byte), 32'h80);
    rd_chk(110, 1'b0);
    host.cmd(1'b0, 1'b1);
    idle();
    chk("status clr", 32'(status_byte), 32'h0);
    host.cmd(1'b1, 1'b0);
    idle();
    chk("flush avail", 32'(avail), 32'h0);
    chk("flush blks", 32'(blk_count), 32'h0);
  endtask : t_pre

  // single block, no pre-trigger; overwrite of scan in transfer
  task automatic t_post();
    wr_n(1025, 3000, 1'b1, 1'b1);
    idle();
    chk("post avail", 32'(avail), 32'd1024);
    chk("ovr bit", 32'(status_byte), 32'h80);
    rd_chk(3001, 1'b0);
    wr_n(1, 3025, 1'b0, 1'b0);
    // overwrite lands on the scan in transfer; next read follows at once
    fork
      wr_n(1, 4000, 1'b0, 1'b0);
      host.get(d, c, ok, 1'b1);
    join
    chk("err valid", 32'(ok), 32'h1);
    chk("err scan", 32'(c), 32'h1);
    rd_chk(3003, 1'b1);
    for (int i = 0; i < 1100 && avail != 0; i++)
      host.get(d, c, ok);
    idle();
    chk("drained", 32'(avail), 32'h0);
    wr_n(1, 7, 1'b1, 1'b1);
    rd_chk(7, 1'b0);
  endtask : t_post

  // four blocks; overrun drops the block being read
  task automatic t_multi();
    host.cmd(1'b1, 1'b1);
    for (int k = 0; k < 4; k++)
      wr_n(256, 5000 + 256 * k, 1'b1, 1'b1);
    idle();
    chk("blks", 32'(blk_count), 32'h4);
    for (int i = 0; i < 3; i++)
      rd_chk(5000 + i, 1'b0);
    wr_n(3, 9000, 1'b0, 1'b0);
    wr_n(1, 9003, 1'b0, 1'b0);
    idle();
    chk("blk dropped", 32'(avail), 32'd772);
    chk("ovr bit", 32'(status_byte), 32'h80);
    chk("blks left", 32'(blk_count), 32'h3);
    chk("renumber", 32'(blk_num), 32'h1);
    rd_chk(5256, 1'b0);
    // read the rest of the new oldest block; it then leaves the count
    for (int i = 1; i < 256; i++)
      host.get(d, c, ok);
    idle();
    chk("last of block", d, 32'd5511);
    chk("blk read out", 32'(blk_count), 32'h2);
  endtask : t_multi

  // verdict and end of run
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_basic();
    t_pre();
    t_post();
    t_multi();
    print_verdict();
  end

  // hang guard, about ten times the expected run
  initial
  begin
    #300000;
    n_errors++;
    print_verdict();
  end
endmodule : acquisition_ring_buffer_overrun_bench
`default_nettype wire
